// *** logic/mbc_block_ctrl.sv ***
`timescale 1ns/1ps
// Operation
// - detector application forces application type to single device
// - light presence only on first block, type single or main only
// - ceiling/presence blocks use configured mode for start and end
// - fully automatic: motion plus brightness starts detection, no manual step
// - manual-on mode ignores all motion until a manual on arrives
// - manual on starts first detection and transmission delay together
// - manual-on mode ends by delay or manual off, then needs new on
// - auto-on/manual-off starts automatically, sends begin, starts no delay
// - auto-on/manual-off ends only on manual off, then ready again
// - auto-on/manual-off mode refused for light presence application
// - bus return behaviour only for single device or main unit
// - basic return: no motion, no delay, no disabling, no telegram
// - basic return with light control drops presence indication
// - disabling return enters disabling and sends disabling begin telegram
// - disabling on bus return records basic as previous state
// - disabling return with light control passes disabling indication
// - detection return enters detection at once, no evaluation delay
// - restore return reloads state held before bus failure
// - skip return behaviour when inactive, walking test or after programming
module mbc_block_ctrl
  import mbc_pkg::*;
#(
  parameter bit FIRST_BLOCK = 1'b1,
  parameter int TICK_CYCLES = MBC_TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins, asynchronous
  input wire logic motion_pin,
  input wire logic bright_ok_pin,
  input wire logic bus_ok_pin,
  // telegram requests and light control
  output logic tx_begin,
  output logic tx_end,
  output logic tx_dis_begin,
  output logic presence_out,
  output logic light_disable_out
);
  // config and control registers
  logic [7:0] cfg_reg, cfg_next;
  logic [2:0] ctrl_reg, ctrl_next;
  logic [15:0] delay_reg, delay_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  // block state
  mbc_state_e st_reg, st_next, prev_reg, prev_next, sv_st_reg, sv_st_next;
  mbc_state_e sv_prev_reg, sv_prev_next;
  logic armed_reg, armed_next, sv_armed_reg, sv_armed_next;
  logic txb_reg, txb_next, txe_reg, txe_next, txd_reg, txd_next;
  logic pres_reg, pres_next, ldis_reg, ldis_next;
  // synchronisers
  logic [1:0] mot_sync, brt_sync, bus_sync;
  logic mot_d, bus_d;
  // decoded
  mbc_app_e app_eff;
  mbc_type_e type_eff;
  mbc_mode_e mode_eff;
  mbc_ret_e ret_cfg;
  logic wr, rd, hit, cmd_wr;
  logic man_on, man_off, motion, dis_on, dis_off;
  logic bus_ret, bus_fail, bright, light;
  logic t_start, t_stop, t_active, t_expire;

  // two-flop synchronisers; edges look only at the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mot_sync <= 2'b00;
      brt_sync <= 2'b00;
      bus_sync <= 2'b00;
      mot_d <= 1'b0;
      bus_d <= 1'b0;
    end else begin
      mot_sync <= {mot_sync[0], motion_pin};
      brt_sync <= {brt_sync[0], bright_ok_pin};
      bus_sync <= {bus_sync[0], bus_ok_pin};
      mot_d <= mot_sync[1];
      bus_d <= bus_sync[1];
    end
  end

  // effective configuration
  always_comb begin
    ret_cfg = mbc_ret_e'(cfg_reg[MBC_CFG_RET_LSB +: 2]);
    app_eff = mbc_app_e'(cfg_reg[MBC_CFG_APP_LSB +: 2]);
    if (app_eff == MBC_APP_LIGHT && !FIRST_BLOCK) begin
      app_eff = MBC_APP_PRESENCE;
    end
    type_eff = mbc_type_e'(cfg_reg[MBC_CFG_TYPE_LSB +: 2]);
    if (app_eff == MBC_APP_DETECTOR || type_eff == MBC_TYPE_RSVD) begin
      type_eff = MBC_TYPE_SINGLE;
    end
    if (app_eff == MBC_APP_LIGHT && type_eff == MBC_TYPE_EXT) begin
      type_eff = MBC_TYPE_SINGLE;
    end
    mode_eff = mbc_mode_e'(cfg_reg[MBC_CFG_MODE_LSB +: 2]);
    if (mode_eff == MBC_MODE_RSVD || app_eff == MBC_APP_DETECTOR) begin
      mode_eff = MBC_MODE_FULL;
    end
    if (app_eff == MBC_APP_LIGHT && mode_eff == MBC_MODE_MAN_OFF) begin
      mode_eff = MBC_MODE_FULL;
    end
  end

  assign light = (app_eff == MBC_APP_LIGHT);
  assign bright = brt_sync[1];
  assign bus_ret = bus_sync[1] && !bus_d;
  assign bus_fail = !bus_sync[1] && bus_d;
  // apb decode; answer in the access cycle, no wait states
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign hit = (paddr[1:0] == 2'b00) && (paddr <= MBC_STATUS_OFS);
  assign cmd_wr = wr && (paddr == MBC_CMD_OFS);
  assign man_on = cmd_wr && pwdata[MBC_CMD_MAN_ON_BIT];
  assign man_off = cmd_wr && pwdata[MBC_CMD_MAN_OFF_BIT];
  assign dis_on = cmd_wr && pwdata[MBC_CMD_DIS_ON_BIT];
  assign dis_off = cmd_wr && pwdata[MBC_CMD_DIS_OFF_BIT];
  assign motion = (mot_sync[1] && !mot_d) || (cmd_wr && pwdata[MBC_CMD_EXT_MOT_BIT]);
  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign pslverr = err_reg;
  always_comb begin
    cfg_next = cfg_reg;
    ctrl_next = ctrl_reg;
    delay_next = delay_reg;
    rdata_next = rdata_reg;
    err_next = psel && !penable && !hit;
    if (rd) begin
      unique case (paddr)
        MBC_CFG_OFS: rdata_next = {24'h00_0000, cfg_reg[7:6], mode_eff, type_eff, app_eff};
        MBC_CTRL_OFS: rdata_next = {29'h0000_0000, ctrl_reg};
        MBC_DELAY_OFS: rdata_next = {16'h0000, delay_reg};
        MBC_STATUS_OFS: rdata_next = {24'h00_0000, ldis_reg, pres_reg, t_active,
                                      armed_reg, prev_reg, st_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (wr && paddr == MBC_CFG_OFS && !ctrl_reg[MBC_CTRL_EN_BIT]) begin
      cfg_next = pwdata[7:0];
    end
    if (wr && paddr == MBC_CTRL_OFS) begin
      ctrl_next = pwdata[2:0];
    end
    if (wr && paddr == MBC_DELAY_OFS) begin
      delay_next = pwdata[15:0];
    end
  end

  // block state machine
  always_comb begin
    st_next = st_reg;
    prev_next = prev_reg;
    armed_next = armed_reg;
    sv_st_next = sv_st_reg;
    sv_prev_next = sv_prev_reg;
    sv_armed_next = sv_armed_reg;
    txb_next = 1'b0;
    txe_next = 1'b0;
    txd_next = 1'b0;
    t_start = 1'b0;
    t_stop = 1'b0;
    if (bus_fail) begin
      sv_st_next = st_reg;
      sv_prev_next = prev_reg;
      sv_armed_next = armed_reg;
    end
    if (bus_ret && ctrl_reg[MBC_CTRL_EN_BIT] && !ctrl_reg[MBC_CTRL_WALK_BIT] &&
        !ctrl_reg[MBC_CTRL_PROG_BIT] &&
        (type_eff == MBC_TYPE_SINGLE || type_eff == MBC_TYPE_MAIN)) begin
      armed_next = 1'b0;
      unique case (ret_cfg)
        MBC_RET_BASIC: begin
          st_next = MBC_ST_BASIC;
          t_stop = 1'b1;
        end
        MBC_RET_DISABLE: begin
          st_next = MBC_ST_DISABLED;
          t_stop = 1'b1;
          txd_next = 1'b1;
          prev_next = MBC_ST_BASIC;
        end
        MBC_RET_DETECT: begin
          st_next = MBC_ST_DETECT;
          txb_next = 1'b1;
          armed_next = (mode_eff == MBC_MODE_MAN_ON);
          t_start = (mode_eff != MBC_MODE_MAN_OFF);
        end
        MBC_RET_RESTORE: begin
          st_next = sv_st_reg;
          prev_next = sv_prev_reg;
          armed_next = sv_armed_reg;
          // delay restarts in full, the remainder is not kept
          t_start = (sv_st_reg == MBC_ST_DETECT) && (mode_eff != MBC_MODE_MAN_OFF);
        end
      endcase
    end else if (st_reg == MBC_ST_DISABLED) begin
      if (dis_off) begin
        st_next = prev_reg;
        t_start = (prev_reg == MBC_ST_DETECT) && (mode_eff != MBC_MODE_MAN_OFF);
      end
    end else if (dis_on) begin
      prev_next = st_reg;
      st_next = MBC_ST_DISABLED;
      t_stop = 1'b1;
      txd_next = 1'b1;
    end else begin
      unique case (mode_eff)
        MBC_MODE_MAN_ON: begin
          if (st_reg == MBC_ST_BASIC) begin
            if (man_on) begin
              st_next = MBC_ST_DETECT;
              armed_next = 1'b1;
              txb_next = 1'b1;
              t_start = 1'b1;
            end
          end else if (man_off || t_expire) begin
            st_next = MBC_ST_BASIC;
            armed_next = 1'b0;
            txe_next = 1'b1;
            t_stop = 1'b1;
          end else if (motion && armed_reg) begin
            t_start = 1'b1;
          end
        end
        MBC_MODE_MAN_OFF: begin
          if (st_reg == MBC_ST_BASIC) begin
            if (motion && bright) begin
              st_next = MBC_ST_DETECT;
              txb_next = 1'b1;
            end
          end else if (man_off) begin
            st_next = MBC_ST_BASIC;
            txe_next = 1'b1;
          end
        end
        default: begin
          if (st_reg == MBC_ST_BASIC) begin
            if (motion && bright) begin
              st_next = MBC_ST_DETECT;
              txb_next = 1'b1;
              t_start = 1'b1;
            end
          end else if (t_expire) begin
            st_next = MBC_ST_BASIC;
            txe_next = 1'b1;
          end else if (motion) begin
            t_start = 1'b1;
          end
        end
      endcase
    end
    pres_next = light && (st_next == MBC_ST_DETECT);
    ldis_next = light && (st_next == MBC_ST_DISABLED);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= MBC_CFG_RST;
      ctrl_reg <= MBC_CTRL_RST;
      delay_reg <= MBC_DELAY_RST;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      st_reg <= MBC_ST_BASIC;
      prev_reg <= MBC_ST_BASIC;
      sv_st_reg <= MBC_ST_BASIC;
      sv_prev_reg <= MBC_ST_BASIC;
      armed_reg <= 1'b0;
      sv_armed_reg <= 1'b0;
      txb_reg <= 1'b0;
      txe_reg <= 1'b0;
      txd_reg <= 1'b0;
      pres_reg <= 1'b0;
      ldis_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      ctrl_reg <= ctrl_next;
      delay_reg <= delay_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      st_reg <= st_next;
      prev_reg <= prev_next;
      sv_st_reg <= sv_st_next;
      sv_prev_reg <= sv_prev_next;
      armed_reg <= armed_next;
      sv_armed_reg <= sv_armed_next;
      txb_reg <= txb_next;
      txe_reg <= txe_next;
      txd_reg <= txd_next;
      pres_reg <= pres_next;
      ldis_reg <= ldis_next;
    end
  end
  assign tx_begin = txb_reg;
  assign tx_end = txe_reg;
  assign tx_dis_begin = txd_reg;
  assign presence_out = pres_reg;
  assign light_disable_out = ldis_reg;
  mbc_delay_timer #(.TICK_CYCLES(TICK_CYCLES), .W(16)) u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .start(t_start),
    .stop(t_stop),
    .len(delay_reg),
    .active(t_active),
    .expire(t_expire)
  );
endmodule // mbc_block_ctrl

// *** include/mbc_pkg.sv ***
package mbc_pkg;
  // apb map, byte addresses
  localparam logic [7:0] MBC_CFG_OFS = 8'h00;
  localparam logic [7:0] MBC_CTRL_OFS = 8'h04;
  localparam logic [7:0] MBC_CMD_OFS = 8'h08;
  localparam logic [7:0] MBC_DELAY_OFS = 8'h0C;
  localparam logic [7:0] MBC_STATUS_OFS = 8'h10;
  // cfg fields
  localparam int MBC_CFG_APP_LSB = 0;
  localparam int MBC_CFG_TYPE_LSB = 2;
  localparam int MBC_CFG_MODE_LSB = 4;
  localparam int MBC_CFG_RET_LSB = 6;
  // ctrl fields
  localparam int MBC_CTRL_EN_BIT = 0;
  localparam int MBC_CTRL_WALK_BIT = 1;
  localparam int MBC_CTRL_PROG_BIT = 2;
  // cmd fields, write-one pulses
  localparam int MBC_CMD_MAN_ON_BIT = 0;
  localparam int MBC_CMD_MAN_OFF_BIT = 1;
  localparam int MBC_CMD_EXT_MOT_BIT = 2;
  localparam int MBC_CMD_DIS_ON_BIT = 3;
  localparam int MBC_CMD_DIS_OFF_BIT = 4;
  // reset values
  localparam logic [7:0] MBC_CFG_RST = 8'h00;
  localparam logic [2:0] MBC_CTRL_RST = 3'h0;
  localparam logic [15:0] MBC_DELAY_RST = 16'h0BB8;
  // timer base: 1 ms tick at 25 MHz
  localparam int MBC_CLK_HZ = 25000000;
  localparam int MBC_TICK_US = 1000;
  localparam int MBC_TICK_CYCLES = MBC_CLK_HZ / 1000000 * MBC_TICK_US;

  typedef enum logic [1:0] {
    MBC_APP_CEILING = 2'b00,
    MBC_APP_PRESENCE = 2'b01,
    MBC_APP_DETECTOR = 2'b10,
    MBC_APP_LIGHT = 2'b11
  } mbc_app_e;

  typedef enum logic [1:0] {
    MBC_TYPE_SINGLE = 2'b00,
    MBC_TYPE_MAIN = 2'b01,
    MBC_TYPE_EXT = 2'b10,
    MBC_TYPE_RSVD = 2'b11
  } mbc_type_e;

  typedef enum logic [1:0] {
    MBC_MODE_FULL = 2'b00,
    MBC_MODE_MAN_ON = 2'b01,
    MBC_MODE_MAN_OFF = 2'b10,
    MBC_MODE_RSVD = 2'b11
  } mbc_mode_e;

  typedef enum logic [1:0] {
    MBC_RET_BASIC = 2'b00,
    MBC_RET_DISABLE = 2'b01,
    MBC_RET_DETECT = 2'b10,
    MBC_RET_RESTORE = 2'b11
  } mbc_ret_e;

  typedef enum logic [1:0] {
    MBC_ST_BASIC = 2'b00,
    MBC_ST_DETECT = 2'b01,
    MBC_ST_DISABLED = 2'b10
  } mbc_state_e;
endpackage

// *** logic/mbc_delay_timer.sv ***
`timescale 1ns/1ps
module mbc_delay_timer
  import mbc_pkg::*;
#(
  parameter int TICK_CYCLES = MBC_TICK_CYCLES,
  parameter int W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] len,
  // status
  output logic active,
  output logic expire
);
  logic [31:0] pre_reg, pre_next;
  logic [W-1:0] cnt_reg, cnt_next;
  logic act_reg, act_next;
  logic exp_reg, exp_next;
  logic tick;

  assign tick = (pre_reg == 32'(TICK_CYCLES - 1));
  assign active = act_reg;
  assign expire = exp_reg;

  always_comb begin
    pre_next = tick ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
    cnt_next = cnt_reg;
    act_next = act_reg;
    exp_next = 1'b0;
    if (stop) begin
      act_next = 1'b0;
    end else if (start) begin
      // retrigger restarts the prescaler so each run is at least len ms
      pre_next = 32'h0000_0000;
      cnt_next = len;
      act_next = 1'b1;
    end else if (act_reg && tick) begin
      if (cnt_reg <= W'(1)) begin
        act_next = 1'b0;
        exp_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 32'h0000_0000;
      cnt_reg <= '0;
      act_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      exp_reg <= exp_next;
    end
  end
endmodule // mbc_delay_timer

// *** tb/mbc_block_ctrl_monitor.sv ***
`timescale 1ns/1ps
module mbc_block_ctrl_monitor
  import mbc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // telegrams and light control
  input wire logic tx_begin,
  input wire logic tx_end,
  input wire logic tx_dis_begin,
  input wire logic presence_out,
  input wire logic light_disable_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire unmapped = (paddr[1:0] != 2'b00) || (paddr > MBC_STATUS_OFS);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_cmd_s;
    psel && penable && !pwrite && paddr == MBC_CMD_OFS;
  endsequence
  ready_high_a: assert property (pready)
    else $error("pready low");
  unmapped_err_a: assert property (setup_s ##1 (psel && penable && unmapped) |-> pslverr)
    else $error("no error on unmapped access");
  mapped_ok_a: assert property (setup_s ##1 (psel && penable && !unmapped) |-> !pslverr)
    else $error("error on mapped access");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  cmd_read_a: assert property (setup_s ##1 rd_cmd_s |-> prdata == 32'h0000_0000)
    else $error("command register reads nonzero");
  begin_pulse_a: assert property (tx_begin |=> !tx_begin)
    else $error("begin request longer than one cycle");
  end_pulse_a: assert property (tx_end |=> !tx_end)
    else $error("end request longer than one cycle");
  dis_pulse_a: assert property ($rose(tx_dis_begin) |=> $fell(tx_dis_begin))
    else $error("disable request longer than one cycle");
  tel_excl_a: assert property (!(tx_begin && tx_end))
    else $error("begin and end together");
  ind_excl_a: assert property (!(presence_out && light_disable_out))
    else $error("presence and disable together");
  reset_quiet_a: assert property ($rose(presetn) |-> !tx_begin && !presence_out)
    else $error("output active after reset");
endmodule // mbc_block_ctrl_monitor

bind mbc_block_ctrl mbc_block_ctrl_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_begin(tx_begin), .tx_end(tx_end), .tx_dis_begin(tx_dis_begin),
  .presence_out(presence_out), .light_disable_out(light_disable_out));

// *** tb/mbc_bus_peer.sv ***
`timescale 1ns/1ps
module mbc_bus_peer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // telegram requests
  input wire logic tx_begin,
  input wire logic tx_end,
  input wire logic tx_dis_begin,
  // counts seen
  output int n_begin,
  output int n_end,
  output int n_dis
);
  // listeners never acknowledge, so only counts are kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_begin <= 0;
      n_end <= 0;
      n_dis <= 0;
    end else begin
      n_begin <= n_begin + int'(tx_begin);
      n_end <= n_end + int'(tx_end);
      n_dis <= n_dis + int'(tx_dis_begin);
    end
  end
endmodule // mbc_bus_peer

// *** tb/mbc_block_ctrl_bench.sv ***
`timescale 1ns/1ps
module mbc_block_ctrl_bench;
  import mbc_pkg::*;
  localparam int TICK = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, lfsr_q;
  logic motion_pin, bright_ok_pin, bus_ok_pin;
  logic tx_begin, tx_end, tx_dis_begin, presence_out, light_disable_out;
  int fails, num_checks, n_begin, n_end, n_dis, nb;
  logic [31:0] exp_q[$], msk_q[$];
  logic [7:0] cw[4] = '{8'h16, 8'h2B, 8'hD5, 8'h3C};
  logic [7:0] ce[4] = '{8'h02, 8'h03, 8'hD5, 8'h00};
  logic [7:0] rc[9] = '{8'h01, 8'h41, 8'h95, 8'hC1, 8'h01, 8'h43, 8'h03, 8'h09, 8'h01};
  logic [7:0] se[9] = '{8'h00, 8'h02, 8'h11, 8'h01, 8'h01, 8'h82, 8'h00, 8'h01, 8'h01};
  logic [7:0] sm[9] = '{8'h83, 8'h8F, 8'h93, 8'h83, 8'h83, 8'h8F, 8'hC3, 8'h83, 8'h83};
  // skip bits: after programming, walk test
  logic [1:0] wk[9] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b01, 2'b00, 2'b00, 2'b00, 2'b10};

  mbc_block_ctrl #(.FIRST_BLOCK(1'b1), .TICK_CYCLES(TICK)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motion_pin(motion_pin), .bright_ok_pin(bright_ok_pin), .bus_ok_pin(bus_ok_pin),
    .tx_begin(tx_begin), .tx_end(tx_end), .tx_dis_begin(tx_dis_begin),
    .presence_out(presence_out), .light_disable_out(light_disable_out));
  mbc_bus_peer peer (.pclk(pclk), .presetn(presetn), .tx_begin(tx_begin), .tx_end(tx_end),
    .tx_dis_begin(tx_dis_begin), .n_begin(n_begin), .n_end(n_end), .n_dis(n_dis));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fails++;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // top byte random: no register uses it
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    lfsr_q = lfsr(lfsr_q);
    apb(a, 1'b1, {lfsr_q[7:0], d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(a, 1'b0, 32'h0000_0000);
  endtask

  task automatic motion;
    motion_pin <= 1'b1;
    cyc(4);
    motion_pin <= 1'b0;
    cyc(8);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      chk("prdata", prdata & msk_q[0], exp_q[0] & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, motion_pin, bus_ok_pin} = 6'h00;
    bright_ok_pin = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    lfsr_q = 32'h0001_48A7;
    cyc(12);
    presetn <= 1'b1;
    rd(MBC_CFG_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(MBC_DELAY_OFS, {16'h0000, MBC_DELAY_RST}, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    chk("pslverr", 32'(last_err), 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      wr(MBC_CFG_OFS, 24'(cw[i]));
      rd(MBC_CFG_OFS, 32'(ce[i]), 32'hFFFF_FFFF);
    end
    wr(MBC_CTRL_OFS, 24'h00_0001);
    wr(MBC_CFG_OFS, 24'h00_0002);
    rd(MBC_CFG_OFS, 32'h0000_0000, 32'h0000_00FF);
    wr(MBC_CTRL_OFS, 24'h00_0000);
    wr(MBC_DELAY_OFS, 24'h00_0005);
    wr(MBC_CFG_OFS, 24'h00_0001);
    wr(MBC_CTRL_OFS, 24'h00_0001);
    motion();
    rd(MBC_STATUS_OFS, 32'h0000_0021, 32'h0000_0023);
    chk("begin", n_begin, 32'd1);
    cyc(40);
    rd(MBC_STATUS_OFS, 32'h0000_0000, 32'h0000_0023);
    chk("end", n_end, 32'd1);
    wr(MBC_CTRL_OFS, 24'h00_0000);
    wr(MBC_CFG_OFS, 24'h00_0011);
    wr(MBC_CTRL_OFS, 24'h00_0001);
    motion();
    // external motion is ignored as well
    wr(MBC_CMD_OFS, 24'h00_0004);
    rd(MBC_STATUS_OFS, 32'h0000_0000, 32'h0000_0003);
    chk("begin", n_begin, 32'd1);
    wr(MBC_CMD_OFS, 24'h00_0001);
    rd(MBC_CMD_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(MBC_STATUS_OFS, 32'h0000_0021, 32'h0000_0023);
    wr(MBC_CMD_OFS, 24'h00_0002);
    rd(MBC_STATUS_OFS, 32'h0000_0000, 32'h0000_0003);
    chk("end", n_end, 32'd2);
    motion();
    rd(MBC_STATUS_OFS, 32'h0000_0000, 32'h0000_0003);
    wr(MBC_CTRL_OFS, 24'h00_0000);
    wr(MBC_CFG_OFS, 24'h00_0021);
    wr(MBC_CTRL_OFS, 24'h00_0001);
    nb = n_begin;
    motion();
    rd(MBC_STATUS_OFS, 32'h0000_0001, 32'h0000_0023);
    chk("begin", n_begin, 32'(nb + 1));
    // disabling round trip must not end a manual-off detection
    wr(MBC_CMD_OFS, 24'h00_0008);
    rd(MBC_STATUS_OFS, 32'h0000_0006, 32'h0000_000F);
    wr(MBC_CMD_OFS, 24'h00_0010);
    rd(MBC_STATUS_OFS, 32'h0000_0001, 32'h0000_0023);
    cyc(40);
    rd(MBC_STATUS_OFS, 32'h0000_0001, 32'h0000_0003);
    wr(MBC_CMD_OFS, 24'h00_0002);
    rd(MBC_STATUS_OFS, 32'h0000_0000, 32'h0000_0003);
    // long delay so detection outlives each return case
    wr(MBC_DELAY_OFS, 24'h00_0032);
    for (int i = 0; i < 9; i++) begin
      wr(MBC_CTRL_OFS, 24'h00_0000);
      wr(MBC_CFG_OFS, 24'(rc[i]));
      wr(MBC_CTRL_OFS, 24'h00_0001);
      motion();
      bus_ok_pin <= 1'b0;
      cyc(8);
      wr(MBC_CTRL_OFS, {21'h0_0000, wk[i], 1'b1});
      bus_ok_pin <= 1'b1;
      cyc(8);
      rd(MBC_STATUS_OFS, 32'(se[i]), 32'(sm[i]));
      chk("presence", 32'(presence_out), 32'(se[i][6]));
      chk("light disable", 32'(light_disable_out), 32'(se[i][7]));
      wr(MBC_CMD_OFS, 24'h00_0010);
    end
    chk("disable telegrams", n_dis, 32'd3);
    // mid-run reset with bus up: the return event must be skipped while inactive
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(8);
    rd(MBC_STATUS_OFS, 32'h0000_0000, 32'h0000_00FF);
    rd(MBC_CFG_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    cyc(4);
    summarize();
  end

  initial begin
    cyc(20000);
    fails++;
    summarize();
  end
endmodule // mbc_block_ctrl_bench
